// ---- burst_sram.v ----
// pipelined burst sram core with strobe decode and byte lanes
`timescale 1ns/1ps
`include "burst_sram_consts.vh"
module burst_sram (
  input wire clk,
  input wire reset,
  input wire [`ADDR_W-1:0] addr,
  input wire primary_select_n,
  input wire depth_select_hi,
  input wire depth_select_lo_n,
  input wire processor_addr_strobe_n,
  input wire controller_addr_strobe_n,
  input wire burst_advance_n,
  input wire all_lanes_write_n,
  input wire lane_write_gate_n,
  input wire [`LANES-1:0] lane_write_n,
  input wire sleep_request,
  input wire burst_mode,
  input wire output_enable_n,
  input wire [`DATA_W-1:0] dq_in,
  output wire [`DATA_W-1:0] dq_out,
  output wire dq_oe
);
  // burst order selected by the mode pin
  localparam [0:0] ORDER_LINEAR = 1'h0;
  localparam [0:0] ORDER_INTERLEAVED = 1'h1;

  // burst state and bus ownership
  reg [`ADDR_W-1:0] base_r;
  reg active_r;
  reg read_r;
  reg write_r;

  // burst address path
  wire [`BURST_W-1:0] offset;
  wire [`BURST_W-1:0] offset_next;
  wire [`BURST_W-1:0] offset_cur;
  wire [`ADDR_W-1:0] acc_addr;

  // strobe and select decode
  wire awake;
  wire selected;
  wire proc_strobe;
  wire ctrl_strobe;
  wire begin_proc;
  wire begin_ctrl;
  wire begin_cyc;
  wire deselect_cyc;
  wire cont_cyc;
  wire step_cyc;

  // write control decode and cycle kinds
  wire write_req;
  wire write_begin;
  wire read_begin;
  wire write_cont;
  wire read_cont;
  wire do_read;
  wire do_write;
  wire bus_free;

  // write request as the master presents it through the lane controls
  function wreq;
    input gw_n;
    input gate_n;
    input [`LANES-1:0] lanes_n;
    begin
      wreq = ~gw_n | (~gate_n & ~(&lanes_n));
    end
  endfunction

  // next offset in either burst order; both orders wrap after four
  function [`BURST_W-1:0] u_next;
    input [`BURST_W-1:0] cur;
    input il;
    input [`BURST_W-1:0] st;
    reg [`BURST_W-1:0] step;
    begin
      step = (cur ^ st) + 2'h1;
      case (il)
        ORDER_INTERLEAVED: begin
          u_next = st ^ step;
        end
        ORDER_LINEAR: begin
          u_next = cur + 2'h1;
        end
        default: begin
          u_next = cur;
        end
      endcase
    end
  endfunction

  // sleep blocks every access, whatever the strobes say
  assign awake = ~sleep_request;

  // depth expansion: all three selects must agree
  assign selected = ~primary_select_n & depth_select_hi & ~depth_select_lo_n;
  assign proc_strobe = ~processor_addr_strobe_n;
  assign ctrl_strobe = ~controller_addr_strobe_n;

  // processor strobe beats the controller strobe when both are low
  assign begin_proc = awake & selected & proc_strobe;
  assign begin_ctrl = awake & selected & ~proc_strobe & ctrl_strobe;

  // either kind of begin reloads the counter
  assign begin_cyc = begin_proc | begin_ctrl;

  // a controller strobe, or a processor strobe with the primary select low, that finds the part unselected closes the burst
  assign deselect_cyc = ~begin_cyc &
    (ctrl_strobe | (proc_strobe & ~primary_select_n));

  // processor strobe is ignored while the primary select is high,
  // so it cannot restart the burst; other chip enables do not matter
  assign cont_cyc = awake & active_r & ~ctrl_strobe &
    (~proc_strobe | primary_select_n);
  assign step_cyc = cont_cyc & ~burst_advance_n;

  // write request as seen by the lanes
  assign write_req = wreq(all_lanes_write_n, lane_write_gate_n, lane_write_n);

  // processor strobe begin always reads, whatever the write controls say
  assign write_begin = begin_ctrl & write_req;
  assign read_begin = begin_proc | (begin_ctrl & ~write_req);
  assign write_cont = cont_cyc & write_req;
  assign read_cont = cont_cyc & ~write_req;
  assign do_write = write_begin | write_cont;
  assign do_read = read_begin | read_cont;

  // counter seeded from the two lowest address bits
  burst_counter u_cnt (
    .clk(clk),
    .reset(reset),
    .load(begin_cyc),
    .advance(step_cyc),
    .start(addr[`BURST_W-1:0]),
    .interleaved(burst_mode), // high or pulled up: interleaved
    .offset(offset)
  );

  // the counter steps at this edge, so the access uses the step ahead
  assign offset_next = u_next(offset, burst_mode, base_r[`BURST_W-1:0]);
  assign offset_cur = step_cyc ? offset_next : offset; // hold

  // begin cycles use the pins, later cycles the held upper bits
  assign acc_addr = begin_cyc ? addr : {base_r[`ADDR_W-1:`BURST_W], offset_cur};

  // burst stays open until a deselect, a new begin, or sleep
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      active_r <= 1'h0;
    end else if (sleep_request) begin
      active_r <= 1'h0; // pending bursts are dropped
    end else if (begin_cyc) begin
      active_r <= 1'h1;
    end else if (deselect_cyc) begin
      active_r <= 1'h0;
    end
  end

  // upper address bits and burst seed kept for the whole burst
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      base_r <= {`ADDR_W{1'b0}};
    end else if (begin_cyc) begin
      base_r <= addr;
    end
  end

  // one array per byte lane so any subset is written in one cycle
  genvar g;
  generate
    for (g = 0; g < `LANES; g = g + 1) begin : lane
      reg [`LANE_W-1:0] mem [0:`DEPTH-1];
      reg [`LANE_W-1:0] q_r;
      wire [`LANE_W-1:0] wdata;
      wire we;

      // data byte plus parity bit of this lane
      assign wdata = dq_in[g*`LANE_W +: `LANE_W];

      // global write takes every lane, else gate low picks lanes low
      assign we = ~all_lanes_write_n | (~lane_write_gate_n & ~lane_write_n[g]);

      // self-timed write, whole lane in one edge
      always @(posedge clk) begin
        if (do_write & we) begin
          mem[acc_addr] <= wdata;
        end
      end

      // registered read, visible one clock after the address
      always @(posedge clk) begin
        if (do_read) begin
          q_r <= mem[acc_addr];
        end
      end

      // lane slice of the registered output word
      assign dq_out[g*`LANE_W +: `LANE_W] = q_r;
    end
  endgenerate

  // read stage flag: the device may own the bus next cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      read_r <= 1'h0;
    end else begin
      read_r <= do_read;
    end
  end

  // write stage flag: keeps the bus released for the taken write
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      write_r <= 1'h0;
    end else begin
      write_r <= do_write;
    end
  end

  // a write presented now or taken last cycle keeps the bus released
  assign bus_free = ~write_r & ~do_write;

  // oe is combinational so the bus releases without waiting a clock
  assign dq_oe = read_r & bus_free & ~output_enable_n;
endmodule

// ---- burst_sram_consts.vh ----
// constants for the pipelined burst sram access block
// Contract
// - controller strobe, selected, write low: begin write
// - selected begin, write high: read, oe gated
// - continue strobes, advance low: next address, read
// - continue strobes, advance low, write: next write
// - advance high, write high: repeat read same address
// - advance high, write low: rewrite same address
// - gate high or all lanes high: read
// - gate low: write only lanes enabled low
// - any lane combination written in one cycle
// - processor strobe always starts a read
// - two-bit counter, interleaved or linear order
// - output enable asynchronous, masked during writes
`ifndef BURST_SRAM_CONSTS_VH
`define BURST_SRAM_CONSTS_VH
`define ADDR_W 18
`define LANES 4
`define LANE_W 9
`define DATA_W 36
`define BURST_W 2
`define DEPTH 262144
`endif

// ---- burst_counter.v ----
// two-bit wraparound burst address counter
`timescale 1ns/1ps
`include "burst_sram_consts.vh"
module burst_counter (
  input wire clk,
  input wire reset,
  input wire load,
  input wire advance,
  input wire [`BURST_W-1:0] start,
  input wire interleaved,
  output wire [`BURST_W-1:0] offset
);
  reg [`BURST_W-1:0] start_r;
  reg [`BURST_W-1:0] count_r;

  // offset follows linear sum or interleaved xor of the step count
  assign offset = interleaved ? (start_r ^ count_r) : (start_r + count_r);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      start_r <= 2'h0;
      count_r <= 2'h0;
    end else if (load) begin
      start_r <= start;
      count_r <= 2'h0;
    end else if (advance) begin
      count_r <= count_r + 2'h1; // wraps after four
    end
  end
endmodule

// ---- burst_sram_asserts.sv ----
// checks on strobe decode and output drive
`timescale 1ns/1ps
module burst_sram_asserts (
  input wire clk,
  input wire reset,
  input wire primary_select_n,
  input wire depth_select_hi,
  input wire depth_select_lo_n,
  input wire processor_addr_strobe_n,
  input wire controller_addr_strobe_n,
  input wire all_lanes_write_n,
  input wire lane_write_gate_n,
  input wire sleep_request,
  input wire output_enable_n,
  input wire dq_oe,
  input wire [3:0] lane_write_n
);
  // selection and write request as presented
  wire sel = !primary_select_n && depth_select_hi && !depth_select_lo_n && !sleep_request;
  wire wr = !all_lanes_write_n || (!lane_write_gate_n && !(&lane_write_n));
  wire rb = sel && !controller_addr_strobe_n && !wr;
  wire wb = sel && !controller_addr_strobe_n && processor_addr_strobe_n && wr;
  wire ok = !output_enable_n && !wr && !sleep_request;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  oe_gate_a:
    assert property (dq_oe |-> !output_enable_n) else $error("oe");
  wr_mask_a:
    assert property (wb |-> !dq_oe) else $error("wr now");
  wr_next_a:
    assert property (wb |=> !dq_oe) else $error("wr next");
  rd_begin_a:
    assert property (rb ##1 ok |-> dq_oe) else $error("rd");
  proc_read_a:
    assert property (sel && !processor_addr_strobe_n ##1 ok |-> dq_oe) else $error("ps");
  cont_read_a:
    assert property (rb ##1 controller_addr_strobe_n && processor_addr_strobe_n && ok ##1 ok
      |-> dq_oe) else $error("cont");
  desel_a:
    assert property (primary_select_n && !controller_addr_strobe_n |=> !dq_oe) else $error("ds");
  sleep_idle_a:
    assert property (sleep_request [*2] |-> !dq_oe) else $error("sleep");
endmodule

// ---- bus_master.sv ----
// bus master model driving the sram pins
`timescale 1ns/1ps
module bus_master (
  input wire clk,
  output reg [17:0] addr = 18'h0,
  output reg [35:0] dq_in = 36'h0,
  output reg [3:0] lane_write_n = 4'hf,
  output wire primary_select_n,
  output wire processor_addr_strobe_n,
  output wire controller_addr_strobe_n,
  output wire burst_advance_n,
  output wire all_lanes_write_n,
  output wire lane_write_gate_n,
  output wire output_enable_n,
  output reg depth_select_hi = 1'b1,
  output reg depth_select_lo_n = 1'b0,
  output reg sleep_request = 1'b0,
  output reg burst_mode = 1'b0
);
  reg [6:0] c_r = 7'h3f;
  assign {output_enable_n, processor_addr_strobe_n, controller_addr_strobe_n,
    burst_advance_n, all_lanes_write_n, lane_write_gate_n, primary_select_n} = c_r;
  // one cycle; data not written toggles so stale values never match
  task go(input [6:0] c, input [17:0] a, input [35:0] d, input [3:0] l);
    reg w;
    begin
      w = !c[2] || (!c[1] && l != 4'hf);
      @(posedge clk);
      c_r <= c | {w, 6'h0};
      addr <= a;
      lane_write_n <= l;
      dq_in <= w ? d : ~dq_in;
    end
  endtask
endmodule

// ---- burst_sram_tb.sv ----
// bench for the burst sram block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module burst_sram_tb;
  localparam [6:0] IDLE = 7'h3f, CR = 7'h2e, BW = 7'h2c;
  reg clk = 0;
  reg reset = 1;
  int num_errors = 0;
  int n_compared = 0;
  int i;
  reg [1:0] k;
  wire [17:0] addr;
  wire [35:0] dq_in, dq_out;
  wire [3:0] lane_write_n;
  wire primary_select_n, depth_select_hi, depth_select_lo_n, processor_addr_strobe_n;
  wire controller_addr_strobe_n, burst_advance_n, all_lanes_write_n, lane_write_gate_n;
  wire sleep_request, burst_mode, output_enable_n, dq_oe;
  always #5 clk = ~clk;
  bus_master m (.*);
  burst_sram dut_u (.*);
  task idle_chk(input [35:0] e);
    begin
      m.go(IDLE, 18'h0, 36'h0, 4'hf);
      #1 `CHK("dq_out", e, dq_out)
    end
  endtask
  // linear write burst, read back by processor strobe with write controls set
  task t_burst;
    begin
      m.go(7'h2a, 18'h101, {9{4'h1}}, 4'hf);
      for (i = 2; i < 5; i++) m.go(7'h32, 18'h0, {9{2'h0, i[1:0]}}, 4'hf);
      for (i = 0; i < 4; i++) begin
        m.go(7'h1a, {16'h40, i[1:0]}, 36'h0, 4'h0);
        idle_chk({9{2'h0, i[1:0]}});
      end
    end
  endtask
  // interleaved read burst from 1, where the orders differ, then a suspend
  task t_inter;
    begin
      @(posedge clk) m.burst_mode <= 1'b1;
      m.go(CR, 18'h101, 36'h0, 4'hf);
      for (i = 1; i < 6; i++) begin
        k = 2'(10'h13a >> (10 - 2 * i));
        m.go(i < 4 ? 7'h36 : (i < 5 ? 7'h3e : IDLE), 18'h0, 36'h0, 4'hf);
        #1 `CHK("seq", {9{2'h0, k}}, dq_out)
        `CHK("oe", 1'b1, dq_oe)
      end
    end
  endtask
  // every lane mask over an all-ones word
  task t_lanes;
    begin
      for (i = 0; i < 16; i++) begin
        m.go(7'h2a, 18'h104, {36{1'b1}}, 4'hf);
        m.go(BW, 18'h104, 36'h0, i[3:0]);
        m.go(BW, 18'h104, 36'h0, 4'hf);
        idle_chk({{9{i[3]}}, {9{i[2]}}, {9{i[1]}}, {9{i[0]}}});
      end
      // gate high: lane enables alone must not write
      m.go(CR, 18'h104, 36'h0, 4'hf);
      m.go(CR, 18'h104, 36'h0, 4'h0);
      m.go(CR, 18'h104, 36'h0, 4'hf);
      idle_chk({36{1'b1}});
    end
  endtask
  // output enable high, deselect, then sleep
  task t_quiet;
    begin
      m.go(7'h6e, 18'h100, 36'h0, 4'hf);
      m.go(7'h7f, 18'h0, 36'h0, 4'hf);
      m.depth_select_hi <= 1'b0;
      #1 `CHK("oe", 1'b0, dq_oe)
      m.go(7'h1e, 18'h100, 36'h0, 4'hf);
      m.go(IDLE, 18'h0, 36'h0, 4'hf);
      #1 `CHK("depth", 1'b0, dq_oe)
      m.go(7'h2f, 18'h100, 36'h0, 4'hf);
      m.depth_select_hi <= 1'b1;
      m.sleep_request <= 1'b1;
      m.go(CR, 18'h100, 36'h0, 4'hf);
      m.go(CR, 18'h100, 36'h0, 4'hf);
      #1 `CHK("idle", 1'b0, dq_oe)
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_burst;
    t_inter;
    t_lanes;
    t_quiet;
    print_verdict;
  end
  // about 115 cycles expected
  initial begin
    #5us;
    num_errors++;
    print_verdict;
  end
endmodule
bind burst_sram burst_sram_asserts chk_u (.*);
